// ===== design/calendar_or_elapsed_select_top.sv
// calendar_or_elapsed_select_top: calendar counter bank and control register file of a real-time clock
// assumes: a serial host front end presents one-cycle byte reads and writes on the register port
// Function
// - calendar mode when select field is zero
// - counters hold packed bcd digits
// - digit fields count 0 to 9, written digits are not range checked
// - unimplemented time bits read zero
// - hundredths count only when enabled, else zero
// - reset to 2000-01-01 saturday, halt flag set
// - seconds carry halt flag, minutes pending bit
// - hour, day, weekday, month, year ranges
// - control bank sits at 24h to 2fh
// - oscillator bit selects 12 or 24 hour
// - year divisible by four gives february 29
// - pending bit mirrors any set flag
// - halt flag sticky, set while oscillator stopped
`timescale 1ns/100ps
module calendar_or_elapsed_select_top
  import calendar_or_elapsed_select_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // register port
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            rvalid_o,
  // oscillator status and event flag sources
  input  wire logic       osc_running_i,
  input  wire logic [7:0] flag_set_i,
  // status
  output logic            halted_o,
  output logic            calendar_mode_o
);
  logic [31:0] presc_ff;
  logic        tick;
  logic [7:0]  trim_ff, osc_ff, bsup_ff, pinf_ff, func_ff, maska_ff, maskb_ff;
  logic [7:0]  flags_ff, scratch_ff, wdog_ff;
  logic        halt_ff;
  logic        osc_halt_ff;
  logic [7:0]  rdata_ff;
  logic        rvalid_ff;
  logic        presc_clr;
  logic        cal_mode;
  logic        centi_en;
  logic        fmt12;
  logic [7:0]  hund, sec, mins, hour, day, wday, mon, year;
  logic        c_hund, c_sec, c_min, c_hour, c_day, c_mon;
  logic        i_hund, i_sec, i_min, i_hour, i_day, i_mon, i_year;
  logic [7:0]  hour_min, hour_max, day_max;
  logic        leap;
  logic        any_flag;
  logic [7:0]  hour_ld;
  logic        day_inc;

  assign cal_mode  = (func_ff[BIT_CAL_SEL] == 1'b0);
  assign centi_en  = func_ff[BIT_CENTI_EN];
  assign fmt12     = osc_ff[BIT_FMT12];
  assign presc_clr = wr_i && (addr_i == ADR_SRST) &&
                     ((wdata_i & SRST_FIXED_MASK) == SRST_FIXED_VAL) && wdata_i[BIT_CLR_PRESC];

  // 100 hz tick divider
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      presc_ff <= 32'h0;
    else if (halt_ff || presc_clr || (presc_ff == 32'(TICK_DIV - 1)))
      presc_ff <= 32'h0;
    else
      presc_ff <= presc_ff + 32'h1;
  end
  assign tick = !halt_ff && cal_mode && !presc_clr && (presc_ff == 32'(TICK_DIV - 1));

  // carry chain
  assign i_hund = tick && centi_en;
  assign i_sec  = centi_en ? c_hund : tick;
  assign i_min  = c_sec;
  assign i_hour = c_min;
  assign i_day  = day_inc;
  assign i_mon  = c_day;
  assign i_year = c_mon;

  // hour range by format
  always_comb
  begin
    if (fmt12)
    begin
      hour_min = 8'h01;
      hour_max = 8'h12;
    end
    else
    begin
      hour_min = 8'h00;
      hour_max = 8'h23;
    end
  end

  // month length
  assign leap = (year[4] == 1'b0) ? (year[1:0] == 2'b00) : (year[1:0] == 2'b10);
  always_comb
  begin
    case (mon)
      8'h02:   day_max = leap ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   day_max = 8'h30;
      default: day_max = 8'h31;
    endcase
  end

  function automatic logic [7:0] wr_field(input logic [7:0] d, input logic [7:0] m);
    wr_field = d & m;
  endfunction

  // 12 hour mode: hour counter holds 01..12 plus afternoon indicator in bit 5
  logic       pm_ff;
  logic [7:0] hour_rd;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pm_ff <= 1'b0;
    else if (wr_i && (addr_i == ADR_HOUR))
      pm_ff <= fmt12 && wdata_i[BIT_PM];
    else if (i_hour && fmt12 && (hour == 8'h11))
      pm_ff <= !pm_ff;
  end
  assign hour_ld = fmt12 ? wr_field(wdata_i, 8'h1f) : wr_field(wdata_i, 8'h3f);
  assign hour_rd = fmt12 ? {2'b00, pm_ff, hour[4:0]} : {2'b00, hour[5:0]};

  // 12 hour mode: the date moves on only at the 11 pm to 12 am step
  always_comb
  begin
    if (fmt12)
      day_inc = i_hour && (hour == 8'h11) && pm_ff;
    else
      day_inc = c_hour;
  end

  calendar_or_elapsed_select_bcd_digit #(.RST_VAL(RST_HUND)) u_hund (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .inc_i      (i_hund),
    .min_i      (8'h00),
    .max_i      (8'h99),
    .load_i     (wr_i && (addr_i == ADR_HUND)),
    .load_val_i (wdata_i),
    .val_o      (hund),
    .carry_o    (c_hund));
  calendar_or_elapsed_select_bcd_digit #(.RST_VAL(RST_SEC)) u_sec (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .inc_i      (i_sec),
    .min_i      (8'h00),
    .max_i      (8'h59),
    .load_i     (wr_i && (addr_i == ADR_SEC)),
    .load_val_i (wr_field(wdata_i, 8'h7f)),
    .val_o      (sec),
    .carry_o    (c_sec));
  calendar_or_elapsed_select_bcd_digit #(.RST_VAL(RST_MIN)) u_min (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .inc_i      (i_min),
    .min_i      (8'h00),
    .max_i      (8'h59),
    .load_i     (wr_i && (addr_i == ADR_MIN)),
    .load_val_i (wr_field(wdata_i, 8'h7f)),
    .val_o      (mins),
    .carry_o    (c_min));
  calendar_or_elapsed_select_bcd_digit #(.RST_VAL(RST_HOUR)) u_hour (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .inc_i      (i_hour),
    .min_i      (hour_min),
    .max_i      (hour_max),
    .load_i     (wr_i && (addr_i == ADR_HOUR)),
    .load_val_i (hour_ld),
    .val_o      (hour),
    .carry_o    (c_hour));
  calendar_or_elapsed_select_bcd_digit #(.RST_VAL(RST_DAY)) u_day (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .inc_i      (i_day),
    .min_i      (8'h01),
    .max_i      (day_max),
    .load_i     (wr_i && (addr_i == ADR_DAY)),
    .load_val_i (wr_field(wdata_i, 8'h3f)),
    .val_o      (day),
    .carry_o    (c_day));
  calendar_or_elapsed_select_bcd_digit #(.RST_VAL(RST_WDAY)) u_wday (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .inc_i      (i_day),
    .min_i      (8'h00),
    .max_i      (8'h06),
    .load_i     (wr_i && (addr_i == ADR_WDAY)),
    .load_val_i (wr_field(wdata_i, 8'h07)),
    .val_o      (wday),
    .carry_o    ());
  calendar_or_elapsed_select_bcd_digit #(.RST_VAL(RST_MON)) u_mon (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .inc_i      (i_mon),
    .min_i      (8'h01),
    .max_i      (8'h12),
    .load_i     (wr_i && (addr_i == ADR_MON)),
    .load_val_i (wr_field(wdata_i, 8'h1f)),
    .val_o      (mon),
    .carry_o    (c_mon));
  calendar_or_elapsed_select_bcd_digit #(.RST_VAL(RST_YEAR)) u_year (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .inc_i      (i_year),
    .min_i      (8'h00),
    .max_i      (8'h99),
    .load_i     (wr_i && (addr_i == ADR_YEAR)),
    .load_val_i (wdata_i),
    .val_o      (year),
    .carry_o    ());

  // oscillator halt flag
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      osc_halt_ff <= 1'b1;
    else if (!osc_running_i)
      osc_halt_ff <= 1'b1;
    else if (wr_i && (addr_i == ADR_SEC))
      osc_halt_ff <= wdata_i[BIT_OSC_HALT];
  end

  // event flags, set wins over clear
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      flags_ff <= RST_CTRL;
    else if (wr_i && (addr_i == ADR_FLAGS))
      flags_ff <= (flags_ff & wdata_i) | flag_set_i;
    else
      flags_ff <= flags_ff | flag_set_i;
  end
  assign any_flag = |flags_ff;

  // control bank
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trim_ff    <= RST_CTRL;
      osc_ff     <= RST_CTRL;
      bsup_ff    <= RST_CTRL;
      pinf_ff    <= RST_CTRL;
      func_ff    <= RST_CTRL;
      maska_ff   <= RST_CTRL;
      maskb_ff   <= RST_CTRL;
      scratch_ff <= RST_CTRL;
      wdog_ff    <= RST_CTRL;
      halt_ff    <= 1'b0;
    end
    else if (wr_i)
    begin
      case (addr_i)
        ADR_TRIM:    trim_ff    <= wdata_i;
        ADR_OSC:     osc_ff     <= wdata_i;
        ADR_BSUP:    bsup_ff    <= {3'b000, wdata_i[4:0]};
        ADR_PINF:    pinf_ff    <= wdata_i;
        ADR_FUNC:    func_ff    <= wdata_i;
        ADR_MASKA:   maska_ff   <= wdata_i;
        ADR_MASKB:   maskb_ff   <= wdata_i;
        ADR_SCRATCH: scratch_ff <= wdata_i;
        ADR_WDOG:    wdog_ff    <= wdata_i;
        ADR_HALT:    halt_ff    <= wdata_i[BIT_HALT];
        default:     halt_ff    <= halt_ff;
      endcase
    end
  end

  // read data
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= rd_i;
      if (rd_i)
      begin
        case (addr_i)
          ADR_HUND:    rdata_ff <= centi_en ? hund : 8'h00;
          ADR_SEC:     rdata_ff <= {osc_halt_ff, sec[6:0]};
          ADR_MIN:     rdata_ff <= {any_flag, mins[6:0]};
          ADR_HOUR:    rdata_ff <= hour_rd;
          ADR_DAY:     rdata_ff <= {2'b00, day[5:0]};
          ADR_WDAY:    rdata_ff <= {5'b00000, wday[2:0]};
          ADR_MON:     rdata_ff <= {3'b000, mon[4:0]};
          ADR_YEAR:    rdata_ff <= year;
          ADR_TRIM:    rdata_ff <= trim_ff;
          ADR_OSC:     rdata_ff <= osc_ff;
          ADR_BSUP:    rdata_ff <= bsup_ff;
          ADR_PINF:    rdata_ff <= pinf_ff;
          ADR_FUNC:    rdata_ff <= func_ff;
          ADR_MASKA:   rdata_ff <= maska_ff;
          ADR_MASKB:   rdata_ff <= maskb_ff;
          ADR_FLAGS:   rdata_ff <= flags_ff;
          ADR_SCRATCH: rdata_ff <= scratch_ff;
          ADR_WDOG:    rdata_ff <= wdog_ff;
          ADR_HALT:    rdata_ff <= {7'h00, halt_ff};
          default:     rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  assign rdata_o         = rdata_ff;
  assign rvalid_o        = rvalid_ff;
  assign halted_o        = halt_ff;
  assign calendar_mode_o = cal_mode;
endmodule // calendar_or_elapsed_select_top

// ===== design/calendar_or_elapsed_select_pkg.sv
// calendar_or_elapsed_select_pkg: register map, field positions, reset values and timing for the rtc counter bank
// assumes: byte-wide register port driven by a serial host front end
package calendar_or_elapsed_select_pkg;
  localparam logic [7:0] ADR_HUND     = 8'h00;
  localparam logic [7:0] ADR_SEC      = 8'h01;
  localparam logic [7:0] ADR_MIN      = 8'h02;
  localparam logic [7:0] ADR_HOUR     = 8'h03;
  localparam logic [7:0] ADR_DAY      = 8'h04;
  localparam logic [7:0] ADR_WDAY     = 8'h05;
  localparam logic [7:0] ADR_MON      = 8'h06;
  localparam logic [7:0] ADR_YEAR     = 8'h07;
  localparam logic [7:0] ADR_TRIM     = 8'h24;
  localparam logic [7:0] ADR_OSC      = 8'h25;
  localparam logic [7:0] ADR_BSUP     = 8'h26;
  localparam logic [7:0] ADR_PINF     = 8'h27;
  localparam logic [7:0] ADR_FUNC     = 8'h28;
  localparam logic [7:0] ADR_MASKA    = 8'h29;
  localparam logic [7:0] ADR_MASKB    = 8'h2a;
  localparam logic [7:0] ADR_FLAGS    = 8'h2b;
  localparam logic [7:0] ADR_SCRATCH  = 8'h2c;
  localparam logic [7:0] ADR_WDOG     = 8'h2d;
  localparam logic [7:0] ADR_HALT     = 8'h2e;
  localparam logic [7:0] ADR_SRST     = 8'h2f;
  // field positions
  localparam int BIT_OSC_HALT   = 7;
  localparam int BIT_ANY_FLAG   = 7;
  localparam int BIT_PM         = 5;
  localparam int BIT_FMT12      = 5;
  localparam int BIT_CENTI_EN   = 7;
  localparam int BIT_CAL_SEL    = 4;
  localparam int BIT_HALT       = 0;
  localparam int BIT_CLR_PRESC  = 7;
  // reset values
  localparam logic [7:0] RST_HUND   = 8'h00;
  localparam logic [7:0] RST_SEC    = 8'h00;
  localparam logic [7:0] RST_MIN    = 8'h00;
  localparam logic [7:0] RST_HOUR   = 8'h00;
  localparam logic [7:0] RST_DAY    = 8'h01;
  localparam logic [7:0] RST_WDAY   = 8'h06;
  localparam logic [7:0] RST_MON    = 8'h01;
  localparam logic [7:0] RST_YEAR   = 8'h00;
  localparam logic [7:0] RST_CTRL   = 8'h00;
  // soft reset command pattern with prescaler clear
  localparam logic [7:0] SRST_FIXED_MASK = 8'h76;
  localparam logic [7:0] SRST_FIXED_VAL  = 8'h24;
  // timing: 100 hz tick from a 100 mhz clock
  localparam int CLK_HZ      = 100000000;
  localparam int TICK_HZ     = 100;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  typedef enum logic [1:0] {CALENDAR_OR_ELAPSED_SELECT_IDLE, CALENDAR_OR_ELAPSED_SELECT_ADVANCE} calendar_or_elapsed_select_state_t;
endpackage

// ===== design/calendar_or_elapsed_select_bcd_digit.sv
// calendar_or_elapsed_select_bcd_digit: two-digit bcd counter stage with programmable range
// assumes: inc_i is a one-cycle pulse, load has priority over counting
`timescale 1ns/100ps
module calendar_or_elapsed_select_bcd_digit
  import calendar_or_elapsed_select_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       inc_i,
  input  wire logic [7:0] min_i,
  input  wire logic [7:0] max_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_val_i,
  // state
  output logic      [7:0] val_o,
  output logic            carry_o
);
  logic [7:0] val_ff;
  logic [7:0] nxt_val;

  always_comb
  begin
    carry_o = inc_i && (val_ff == max_i);
    if (carry_o)
      nxt_val = min_i;
    else if (val_ff[3:0] >= 4'h9)
      nxt_val = {val_ff[7:4] + 4'h1, 4'h0};
    else
      nxt_val = {val_ff[7:4], val_ff[3:0] + 4'h1};
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      val_ff <= RST_VAL;
    else if (load_i)
      val_ff <= load_val_i;
    else if (inc_i)
      val_ff <= nxt_val;
  end

  assign val_o = val_ff;
endmodule // calendar_or_elapsed_select_bcd_digit

// ===== bench/calendar_or_elapsed_select_top_chk.sv
// calendar_or_elapsed_select_top_chk: port-level assertions for the rtc counter bank
// assumes: bound to calendar_or_elapsed_select_top, one clock domain
`timescale 1ns/100ps
module calendar_or_elapsed_select_top_chk
  import calendar_or_elapsed_select_pkg::*;
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // register port
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rvalid_o,
  // status
  input wire logic       osc_running_i,
  input wire logic [7:0] flag_set_i,
  input wire logic       halted_o,
  input wire logic       calendar_mode_o
);
  logic centi_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      centi_ff <= 1'b0;
    else if (wr_i && addr_i == ADR_FUNC)
      centi_ff <= wdata_i[BIT_CENTI_EN];
  property p_rd_ans; rd_i |=> rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_unmap; rd_i && ((addr_i > 8'h07 && addr_i < 8'h24) || addr_i > 8'h2e) |-> ##1 rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_wday; rd_i && addr_i == ADR_WDAY |=> rdata_o[7:3] == 5'h00; endproperty
  a_wday: assert property (p_wday) else $error("weekday spare bits set");
  property p_halt_reg; rd_i && addr_i == ADR_HALT |=> rdata_o[7:1] == 7'h00 && rdata_o[0] == $past(halted_o); endproperty
  a_halt_reg: assert property (p_halt_reg) else $error("halt register bits wrong");
  property p_halt_out; wr_i && addr_i == ADR_HALT |=> halted_o == $past(wdata_i[BIT_HALT]); endproperty
  a_halt_out: assert property (p_halt_out) else $error("halt output not updated");
  property p_hund; rd_i && addr_i == ADR_HUND && !centi_ff |=> rdata_o == 8'h00; endproperty
  a_hund: assert property (p_hund) else $error("hundredths not zero");
  property p_osc; rd_i && addr_i == ADR_SEC && !osc_running_i && !$past(osc_running_i) |=> rdata_o[7]; endproperty
  a_osc: assert property (p_osc) else $error("halt flag clear while stopped");
  property p_pend; rd_i && addr_i == ADR_MIN && !$past(rst_i) && $past(flag_set_i) != 8'h00 |=> rdata_o[7]; endproperty
  a_pend: assert property (p_pend) else $error("pending bit clear");
  property p_sec_bcd; rd_i && addr_i == ADR_SEC |=> rdata_o[6:4] <= 3'h5 && rdata_o[3:0] <= 4'h9; endproperty
  a_sec_bcd: assert property (p_sec_bcd) else $error("seconds digits out of range");
  property p_cal; wr_i && addr_i == ADR_FUNC |=> calendar_mode_o == !$past(wdata_i[BIT_CAL_SEL]); endproperty
  a_cal: assert property (p_cal) else $error("calendar mode wrong");
  c_sec: cover property (rd_i && addr_i == ADR_SEC);
  c_flag: cover property (flag_set_i != 8'h00);
  c_func: cover property (wr_i && addr_i == ADR_FUNC);
endmodule // calendar_or_elapsed_select_top_chk
bind calendar_or_elapsed_select_top calendar_or_elapsed_select_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .osc_running_i(osc_running_i),
  .flag_set_i(flag_set_i), .halted_o(halted_o), .calendar_mode_o(calendar_mode_o));

// ===== bench/calendar_or_elapsed_select_host.sv
// calendar_or_elapsed_select_host: host stand-in making byte register accesses
// assumes: strobes are taken on the rising edge, answer one cycle later
`timescale 1ns/100ps
module calendar_or_elapsed_select_host
(
  // clock and answer
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  // register port
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  logic [7:0] last_rd = 8'h00;
  initial {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
  // one access, held over one rising edge; idle bus shows inverted values
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {wr_o, rd_o, addr_o, wdata_o} <= {w, !w, a, d};
    @(negedge clk_i);
    {wr_o, rd_o, addr_o, wdata_o} <= {2'b00, ~a, ~d};
    if (rvalid_i === 1'b1)
      last_rd = rdata_i;
  endtask
endmodule // calendar_or_elapsed_select_host

// ===== bench/test_calendar_or_elapsed_select_top.sv
// test_calendar_or_elapsed_select_top: self-checking bench for the rtc counter bank
// assumes: calendar_or_elapsed_select_host drives the register port, bench drives status inputs
`timescale 1ns/100ps
module test_calendar_or_elapsed_select_top;
  import calendar_or_elapsed_select_pkg::*;
  logic clk_i = 0, rst_i = 1, osc_running_i = 1, wr_i, rd_i, rvalid_o, halted_o, calendar_mode_o;
  logic [7:0] flag_set_i = 8'h00, addr_i, wdata_i, rdata_o, rw;
  logic [7:0] exp_q[$];
  int err_total = 0, checked = 0, seed = 32'h4c5ad73c, n;
  logic [7:0] rst_v[8] = '{RST_HUND, RST_SEC | 8'h80, RST_MIN, RST_HOUR, RST_DAY, RST_WDAY, RST_MON, RST_YEAR};
  logic [7:0] bad[5] = '{8'h08, 8'h23, 8'h2f, 8'h30, 8'hff};
  // hour day wday month year osc, then expected hour day wday month year
  logic [7:0] rows[7][11] = '{'{8'h23, 8'h28, 8'h06, 8'h02, 8'h04, 8'h00, 8'h00, 8'h29, 8'h00, 8'h02, 8'h04},
    '{8'h23, 8'h28, 8'h03, 8'h02, 8'h05, 8'h00, 8'h00, 8'h01, 8'h04, 8'h03, 8'h05},
    '{8'h23, 8'h31, 8'h05, 8'h12, 8'h99, 8'h00, 8'h00, 8'h01, 8'h06, 8'h01, 8'h00},
    '{8'h11, 8'h10, 8'h01, 8'h05, 8'h20, 8'h20, 8'h32, 8'h10, 8'h01, 8'h05, 8'h20},
    '{8'h09, 8'h15, 8'h02, 8'h07, 8'h21, 8'h00, 8'h10, 8'h15, 8'h02, 8'h07, 8'h21},
    '{8'h31, 8'h10, 8'h01, 8'h05, 8'h20, 8'h20, 8'h12, 8'h11, 8'h02, 8'h05, 8'h20},
    '{8'h32, 8'h10, 8'h01, 8'h05, 8'h20, 8'h20, 8'h21, 8'h10, 8'h01, 8'h05, 8'h20}};
  always #5 clk_i = ~clk_i;
  calendar_or_elapsed_select_top #(.TICK_DIV(10)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .osc_running_i(osc_running_i),
    .flag_set_i(flag_set_i), .halted_o(halted_o), .calendar_mode_o(calendar_mode_o));
  calendar_or_elapsed_select_host host (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o), .wr_o(wr_i), .rd_o(rd_i),
    .addr_o(addr_i), .wdata_o(wdata_i));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d);
  endtask
  task chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask
  // oldest expectation meets each read answer
  always @(negedge clk_i)
    if (rvalid_o === 1'b1 && exp_q.size() > 0)
      cmp(rdata_o, exp_q.pop_front());
  // load a date at 59:59, let one tick pass, stop and read back
  task roll(input int r);
    wr(ADR_HALT, 8'h01);
    wr(ADR_OSC, rows[r][5]);
    wr(ADR_SEC, 8'h59);
    wr(ADR_MIN, 8'h59);
    for (int i = 0; i < 5; i++)
      wr(8'(ADR_HOUR + i), rows[r][i]);
    wr(ADR_HALT, 8'h00);
    repeat (8) wr(ADR_SRST, 8'ha4);
    chk(ADR_SEC, 8'h59);
    rw = 8'h59;
    for (n = 0; n < 60 && rw === 8'h59; n++)
    begin
      host.acc(1'b0, ADR_SEC, 8'h00);
      rw = host.last_rd;
    end
    wr(ADR_HALT, 8'h01);
    if (n == 60)
    begin
      err_total++;
      close_out;
    end
    chk(ADR_SEC, 8'h00);
    chk(ADR_MIN, 8'h00);
    for (int i = 0; i < 5; i++)
      chk(8'(ADR_HOUR + i), rows[r][6 + i]);
    wr(ADR_OSC, 8'h00);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i) rst_i = 0;
    wr(ADR_HALT, 8'h01);
    cmp({7'h0, halted_o}, 8'h01);
    chk(ADR_HALT, 8'h01);
    for (int i = 0; i < 8; i++)
      chk(8'(i), rst_v[i]);
    $display("reset values done");
    for (int a = 'h24; a < 'h2e; a++)
      if (a != 'h2b)
      begin
        rw = 8'($random(seed));
        wr(8'(a), rw);
        chk(8'(a), (a == 'h26) ? (rw & 8'h1f) : rw);
        wr(8'(a), 8'h00);
      end
    wr(ADR_SRST, 8'h5a);
    foreach (bad[i])
      chk(bad[i], 8'h00);
    $display("register map done");
    for (int r = 0; r < 7; r++)
      roll(r);
    $display("rollover done");
    wr(ADR_FUNC, 8'h80);
    wr(ADR_HUND, 8'h42);
    chk(ADR_HUND, 8'h42);
    wr(ADR_FUNC, 8'h00);
    chk(ADR_HUND, 8'h00);
    rw = 8'h01 << ($random(seed) & 7);
    flag_set_i = rw;
    @(negedge clk_i) flag_set_i = 8'h00;
    wr(ADR_MIN, 8'h00);
    chk(ADR_MIN, 8'h80);
    chk(ADR_FLAGS, rw);
    flag_set_i = rw;
    wr(ADR_FLAGS, 8'h00);
    flag_set_i = 8'h00;
    chk(ADR_FLAGS, rw);
    wr(ADR_FLAGS, 8'h00);
    chk(ADR_MIN, 8'h00);
    osc_running_i = 0;
    wr(ADR_SEC, 8'h00);
    chk(ADR_SEC, 8'h80);
    osc_running_i = 1;
    wr(ADR_SEC, 8'h00);
    chk(ADR_SEC, 8'h00);
    wr(ADR_FUNC, 8'h10);
    cmp({7'h0, calendar_mode_o}, 8'h00);
    wr(ADR_FUNC, 8'h00);
    cmp({7'h0, calendar_mode_o}, 8'h01);
    $display("flags and modes done");
    repeat (3) @(negedge clk_i);
    if (exp_q.size() > 0)
      err_total++;
    close_out;
  end
endmodule // test_calendar_or_elapsed_select_top
